// [logic/anr_regs.sv]
// auto-negotiation register group behind a serial management slave
//
// How it works
// (R1) advert bit 15 is a writable next-page request flag, reset zero
// (R2) host must never set advert remote-fault bit 13; it resets zero
// (R3) advert bits 11 and 10 are writable pause abilities, reset zero
// (R4) advert bit 9, four-pair ability, is read-only and always zero
// (R5) advert bits 8..6 writable, reset one, strap-loaded in basic pin mode
// (R6) advert bit 5 writable, reset one, strap-loaded in both pin modes
// (R7) in forced speed/duplex mode the four ability bits have no effect
// (R8) advert selector bits 4..0 writable, reset to 00001
// (R9) partner register is read-only, captures received base page, resets zero
// (R10) partner bit 15 shows partner next-page request
// (R11) partner bit 14 shows partner acknowledge of our code word
// (R12) partner bit 13 shows partner remote-fault advertisement
// (R13) partner bits 11, 10 show partner pause abilities; bit 12 reads zero
// (R14) partner bits 9..5 show partner speed/duplex abilities
// (R15) partner bits 4..0 hold received selector, zero after reset
// (R16) expansion resets to 0004h with bits 15..5 reading zero
// (R17) expansion bit 4 set by hardware on parallel detection fault
// (R18) expansion bit 3 shows partner next-page ability, read-only
// (R19) expansion bit 2 reads one, local next-page ability
// (R20) expansion bit 1 set by hardware when a new page arrives
// (R21) expansion bit 0 shows partner auto-negotiation ability, read-only
// (R22) next-page transmit register at address 7, reset 2001h
// (R23) advert register at address 4, reset 01E1h
// (R24) host sends full 32-bit preamble once after reset or bad frame
// (R25) host leaves 500 ns gap and one idle-high clock edge between frames
// (R26) expansion bits 4 and 1 latch until read or reset
module anr_regs
  import anr_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
)(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // management pins
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  // strap pins, sampled at reset release
  input  wire logic        basic_mode_i,
  input  wire logic [3:0]  strap_adv_i,
  // negotiation side
  input  wire logic        force_mode_i,
  input  wire logic        lp_page_valid_i,
  input  wire logic [15:0] lp_page_i,
  input  wire logic        lp_an_able_i,
  input  wire logic        lp_np_able_i,
  input  wire logic        pd_fault_i,
  output logic [15:0]      advert_o,
  output logic [15:0]      next_page_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [6:0]  pin_s;
  logic        mdc_s;
  logic        mdio_s;
  logic        basic_s;
  logic [3:0]  strap_s;
  logic        mdc_d;
  logic        mdc_rise;

  anr_sync2 #(
    .WIDTH (7)
  ) u_sync (
    .clk_i (sys_clk_i),
    .d_i   ({mdc_i, mdio_i, basic_mode_i, strap_adv_i}),
    .q_o   (pin_s)
  );

  // split synchronised pins
  assign mdc_s   = pin_s[6];
  assign mdio_s  = pin_s[5];
  assign basic_s = pin_s[4];
  assign strap_s = pin_s[3:0];

  // management clock edge finder
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mdc_d <= 1'b1;
    end else begin
      mdc_d <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_d;

  ////////////////////////////////////////////////////////////////////////////
  // management frame engine

  anr_state_t  state;
  logic [3:0]  bit_cnt;
  logic [5:0]  ones_cnt;
  logic        pre_ok;
  logic        op_hi;
  logic        is_read;
  logic [9:0]  addr_sh;
  logic [15:0] shreg;
  logic        phy_hit;
  logic [4:0]  reg_addr;
  logic        rd_load;
  logic        wr_en;
  logic [15:0] wdata;
  logic [15:0] rd_mux;

  assign phy_hit  = (addr_sh[9:5] == PHY_ADDR);
  assign reg_addr = addr_sh[4:0];

  // read data is fetched as the first turnaround bit passes
  assign rd_load = mdc_rise && (state == ST_TA1) && is_read && phy_hit;

  // write commits on the last data bit
  assign wr_en = mdc_rise && (state == ST_DATA) && (bit_cnt == DATA_LAST) &&
                 !is_read && phy_hit;
  assign wdata = {shreg[14:0], mdio_s};

  // frame sequencing and preamble tracking
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      ones_cnt <= 6'h00;
      pre_ok   <= 1'b0;
      op_hi    <= 1'b0;
      is_read  <= 1'b0;
      addr_sh  <= 10'h000;
    end else if (mdc_rise) begin
      case (state)
        ST_IDLE: begin
          if (mdio_s) begin
            if (ones_cnt != PRE_LEN) begin
              ones_cnt <= ones_cnt + 6'h01;
            end else begin
              pre_ok <= 1'b1;  // see (R24)
            end
          end else if (pre_ok || ones_cnt == PRE_LEN) begin
            state    <= ST_START;  // see (R24)
            pre_ok   <= 1'b1;  // later frames may skip the preamble, see (R24)
            ones_cnt <= 6'h00;
          end else begin
            ones_cnt <= 6'h00;
          end
        end
        ST_START: begin
          state   <= mdio_s ? ST_OP : ST_IDLE;
          bit_cnt <= 4'h0;
        end
        ST_OP: begin
          if (bit_cnt == 4'h0) begin
            op_hi   <= mdio_s;
            bit_cnt <= 4'h1;
          end else if ({op_hi, mdio_s} == OP_READ || {op_hi, mdio_s} == OP_WRITE) begin
            is_read <= ({op_hi, mdio_s} == OP_READ);
            state   <= ST_ADDR;
            bit_cnt <= 4'h0;
          end else begin
            pre_ok <= 1'b0;  // see (R24)
            state  <= ST_IDLE;
          end
        end
        ST_ADDR: begin
          addr_sh <= {addr_sh[8:0], mdio_s};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == ADDR_LAST) begin
            state <= ST_TA1;
          end
        end
        ST_TA1: begin
          if (!is_read && !mdio_s) begin
            pre_ok <= 1'b0;  // see (R24)
            state  <= ST_IDLE;
          end else begin
            state <= ST_TA2;
          end
        end
        ST_TA2: begin
          bit_cnt <= 4'h0;
          if (!is_read && mdio_s) begin
            pre_ok <= 1'b0;  // see (R24)
            state  <= ST_IDLE;
          end else begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == DATA_LAST) begin
            state <= ST_IDLE;  // idle-high edge expected next, see (R25)
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // data shifter and pin drive
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      shreg     <= 16'h0000;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (mdc_rise) begin
      if (rd_load) begin
        shreg     <= rd_mux;
        mdio_oe_o <= 1'b1;  // drive the second turnaround bit low
        mdio_o    <= 1'b0;
      end else if (state == ST_TA2 && is_read) begin
        mdio_o <= shreg[15];
        shreg  <= {shreg[14:0], 1'b0};
      end else if (state == ST_DATA) begin
        if (is_read) begin
          mdio_o <= shreg[15];
          shreg  <= {shreg[14:0], 1'b0};
        end else begin
          shreg <= wdata;
        end
        if (bit_cnt == DATA_LAST) begin
          mdio_oe_o <= 1'b0;
          mdio_o    <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic        strap_done;
  logic [15:0] advert;
  logic [15:0] partner;
  logic [15:0] next_page;
  logic        pd_fault;
  logic        page_rx;
  logic        lp_np;
  logic        lp_an;
  logic        exp_rd;

  assign exp_rd = rd_load && (reg_addr == ADDR_EXPANSION);

  // read multiplexer
  always_comb begin
    case (reg_addr)
      ADDR_ADVERT:    rd_mux = advert;
      ADDR_PARTNER:   rd_mux = partner;
      ADDR_EXPANSION: rd_mux = {{EXP_RSVD_W{1'b0}}, pd_fault, lp_np, 1'b1,
                                page_rx, lp_an};  // see (R16) (R19)
      ADDR_NEXT_PAGE: rd_mux = next_page;
      default:        rd_mux = RD_UNMAPPED;
    endcase
  end

  // strap capture happens in the first cycle after reset release
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  // local advertisement word
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      advert <= RST_ADVERT;  // see (R1) (R2) (R3) (R5) (R6) (R8) (R23)
    end else if (!strap_done) begin
      if (basic_s) begin
        advert[ADV_TX_FD:ADV_10_FD] <= strap_s[3:1];  // see (R5)
      end
      advert[ADV_10_HD] <= strap_s[0];  // see (R6)
    end else if (wr_en && reg_addr == ADDR_ADVERT) begin
      advert <= wdata & ADV_WMASK;  // bits 14, 12, 9 stay zero, see (R4)
    end
  end

  // effective advertisement toward the arbitration logic
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      advert_o <= RST_ADVERT;
    end else if (force_mode_i) begin
      advert_o <= advert & ~ADV_SPEED_MASK;  // see (R7)
    end else begin
      advert_o <= advert;
    end
  end

  // partner base page capture
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      partner <= RST_PARTNER;  // see (R9) (R15)
    end else if (lp_page_valid_i) begin
      // np, ack, rf, pause, abilities, selector as received
      partner <= lp_page_i & PARTNER_MASK;  // see (R10) (R11) (R12) (R13) (R14) (R15)
    end
  end

  // expansion status: sticky pd_fault and page_rx, set wins over read clear; lp_np and lp_an follow their inputs
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pd_fault <= RST_EXPANSION[EXP_PD_FAULT];
      page_rx  <= RST_EXPANSION[EXP_PAGE_RX];
      lp_np    <= RST_EXPANSION[EXP_LP_NP];
      lp_an    <= RST_EXPANSION[EXP_LP_AN];
    end else begin
      pd_fault <= pd_fault_i | (pd_fault & ~exp_rd);  // see (R17) (R26)
      page_rx  <= lp_page_valid_i | (page_rx & ~exp_rd);  // see (R20) (R26)
      lp_np    <= lp_np_able_i;  // see (R18)
      lp_an    <= lp_an_able_i;  // see (R21)
    end
  end

  // next-page transmit word
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      next_page   <= RST_NEXT_PAGE;  // see (R22)
      next_page_o <= RST_NEXT_PAGE;
    end else begin
      if (wr_en && reg_addr == ADDR_NEXT_PAGE) begin
        next_page <= wdata & NP_WMASK;  // see (R22)
      end
      next_page_o <= next_page;
    end
  end

endmodule

// [inc/anr_pkg.sv]
// constants and types for the auto-negotiation register group
package anr_pkg;

  // management register addresses
  localparam logic [4:0]  ADDR_ADVERT    = 5'h04;
  localparam logic [4:0]  ADDR_PARTNER   = 5'h05;
  localparam logic [4:0]  ADDR_EXPANSION = 5'h06;
  localparam logic [4:0]  ADDR_NEXT_PAGE = 5'h07;

  // reset values
  localparam logic [15:0] RST_ADVERT     = 16'h01E1;
  localparam logic [15:0] RST_PARTNER    = 16'h0000;
  localparam logic [15:0] RST_EXPANSION  = 16'h0004;
  localparam logic [15:0] RST_NEXT_PAGE  = 16'h2001;
  localparam logic [15:0] RD_UNMAPPED    = 16'h0000;

  // advertisement field positions
  localparam int ADV_NP      = 15;
  localparam int ADV_RF      = 13;
  localparam int ADV_ASYM    = 11;
  localparam int ADV_PAUSE   = 10;
  localparam int ADV_T4      = 9;
  localparam int ADV_TX_FD   = 8;
  localparam int ADV_10_FD   = 6;
  localparam int ADV_10_HD   = 5;

  // writable bits: 15, 13, 11, 10, 8..0
  localparam logic [15:0] ADV_WMASK      = 16'hADFF;
  // speed/duplex ability bits 8..5
  localparam logic [15:0] ADV_SPEED_MASK = 16'h01E0;
  // partner bits kept: all but reserved bit 12
  localparam logic [15:0] PARTNER_MASK   = 16'hEFFF;
  // next page writable: 15, 13, 12, 10..0
  localparam logic [15:0] NP_WMASK       = 16'hB7FF;

  // expansion field positions
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP    = 3;
  localparam int EXP_LOC_NP   = 2;
  localparam int EXP_PAGE_RX  = 1;
  localparam int EXP_LP_AN    = 0;
  localparam int EXP_RSVD_W   = 11;

  // management frame layout
  localparam logic [5:0]  PRE_LEN   = 6'h20;
  localparam logic [3:0]  ADDR_LAST = 4'h9;
  localparam logic [3:0]  DATA_LAST = 4'hF;
  localparam logic [1:0]  OP_READ   = 2'b10;
  localparam logic [1:0]  OP_WRITE  = 2'b01;

  // management frame states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_OP    = 3'b010,
    ST_ADDR  = 3'b011,
    ST_TA1   = 3'b100,
    ST_TA2   = 3'b101,
    ST_DATA  = 3'b110
  } anr_state_t;

endpackage

// [logic/anr_sync2.sv]
// two-flop synchroniser for pin inputs
module anr_sync2 #(
  parameter int WIDTH = 1
)(
  // clock
  input  wire logic             clk_i,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o  <= meta;
  end

endmodule

// [verification/anr_regs_checker.sv]
// assertion checker for the auto-negotiation register group
module anr_regs_checker
  import anr_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  // straps and mode
  input wire logic        basic_mode_i,
  input wire logic [3:0]  strap_adv_i,
  input wire logic        force_mode_i,
  // register copies
  input wire logic [15:0] advert_o,
  input wire logic [15:0] next_page_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  // values seen on the first edges out of reset
  AST_ADV_RST: assert property ($rose(rstn_i) |-> advert_o == RST_ADVERT)
    else $error("advert reset value wrong");
  AST_NP_RST: assert property ($rose(rstn_i) |-> next_page_o == RST_NEXT_PAGE)
    else $error("next page reset value wrong");
  AST_NEXT_REQ: assert property ($rose(rstn_i) |=> !advert_o[15])
    else $error("next page request not clear");
  AST_PAUSE: assert property ($rose(rstn_i) |=> advert_o[11:10] == 2'b00)
    else $error("pause bits not clear");
  AST_SELECT: assert property ($rose(rstn_i) |=> advert_o[4:0] == 5'h01)
    else $error("selector wrong");
  // strap loads, judged once the load has landed
  AST_STRAP_HI: assert property (
    $rose(rstn_i) ##2 !force_mode_i [*2]
    |-> advert_o[8:6] == (basic_mode_i ? strap_adv_i[3:1] : 3'b111))
    else $error("upper ability straps wrong");
  AST_STRAP_LO: assert property (
    $rose(rstn_i) ##2 !force_mode_i [*2] |-> advert_o[5] == strap_adv_i[0])
    else $error("lower ability strap wrong");
  // fixed and masked bits
  AST_T4_ZERO: assert property (advert_o[9] == 1'b0)
    else $error("four-pair bit set");
  AST_FORCE: assert property (force_mode_i |=> advert_o[8:5] == 4'h0)
    else $error("abilities not masked when forced");
endmodule
////////////////////////////////////////
bind anr_regs anr_regs_checker anr_regs_checker_i (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .basic_mode_i(basic_mode_i),
  .strap_adv_i(strap_adv_i), .force_mode_i(force_mode_i),
  .advert_o(advert_o), .next_page_o(next_page_o));

// [verification/anr_mdio_host.sv]
// management host model clocking serial frames into the device
module anr_mdio_host
  import anr_pkg::*;
(
  // clock
  input  wire logic sys_clk_i,
  // management pins
  input  wire logic pin_i,
  output logic      mdc_o,
  output logic      md_o,
  output logic      md_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pre_due;
  logic s;
  ////////////////////////////////////////
  // idle: clock low, data left to the pull-up
  initial begin
    mdc_o = 1'b0;
    md_o = 1'b1;
    md_en_o = 1'b0;
    pre_due = 1'b1;
  end
  // one bit: drive in low phase, sample just before the rise
  task automatic bit_x(input logic d, input logic en);
    #1 mdc_o = 1'b0;
    md_o = d;
    md_en_o = en;
    repeat (6) @(posedge sys_clk_i);
    #1 s = pin_i;
    mdc_o = 1'b1;
    repeat (6) @(posedge sys_clk_i);
  endtask
  // whole frame, preamble only when owed, then idle-high gap
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        wr;
    hdr = {2'b01, op, phy, ra};
    wr = (op != OP_READ);
    if (pre_due) repeat (32) bit_x(1'b1, 1'b1);
    pre_due = !(op inside {OP_READ, OP_WRITE});
    for (int i = 13; i >= 0; i--) bit_x(hdr[i], 1'b1);
    bit_x(1'b1, wr);
    bit_x(1'b0, wr);
    for (int i = 15; i >= 0; i--) begin
      bit_x(wd[i], wr);
      rd[i] = s;
    end
    repeat (6) bit_x(1'b1, 1'b0);
  endtask
endmodule

// [verification/anr_regs_tb.sv]
// self-checking bench for the auto-negotiation register group
module anr_regs_tb
  import anr_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] PHY = 5'h03; // arbitrary management address
  logic        sys_clk_i;
  logic        rstn_i;
  logic        mdc;
  logic        mdio_w;
  logic        dev_o;
  logic        dev_oe;
  logic        host_d;
  logic        host_en;
  logic        basic_mode_i;
  logic [3:0]  strap_adv_i;
  logic        force_mode_i;
  logic        lp_page_valid_i;
  logic [15:0] lp_page_i;
  logic        lp_an_able_i;
  logic        lp_np_able_i;
  logic        pd_fault_i;
  logic [15:0] advert_o;
  logic [15:0] next_page_o;
  logic [15:0] rv;
  int          bad_count;
  int          samples_checked;
  ////////////////////////////////////////
  // wire level: device when enabled, else host, else pull-up
  assign mdio_w = dev_oe ? dev_o : (host_en ? host_d : 1'b1);
  anr_regs #(.PHY_ADDR(PHY)) anr_regs_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(dev_o), .mdio_oe_o(dev_oe), .basic_mode_i(basic_mode_i),
    .strap_adv_i(strap_adv_i), .force_mode_i(force_mode_i),
    .lp_page_valid_i(lp_page_valid_i), .lp_page_i(lp_page_i),
    .lp_an_able_i(lp_an_able_i), .lp_np_able_i(lp_np_able_i),
    .pd_fault_i(pd_fault_i), .advert_o(advert_o), .next_page_o(next_page_o));
  anr_mdio_host anr_mdio_host_i (
    .sys_clk_i(sys_clk_i), .pin_i(mdio_w), .mdc_o(mdc), .md_o(host_d), .md_en_o(host_en));
  // 125 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////
  // counts, verdict and end of run
  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register read and write over the management pins
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    anr_mdio_host_i.frame(OP_READ, PHY, a, 16'h0000, rv);
    chk(rv, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    anr_mdio_host_i.frame(OP_WRITE, PHY, a, d, rv);
  endtask
  // reset with given straps; host owes a preamble again
  task automatic do_reset(input logic b, input logic [3:0] s);
    @(posedge sys_clk_i) #1 rstn_i = 1'b0;
    basic_mode_i = b;
    strap_adv_i = s;
    repeat (6) @(posedge sys_clk_i);
    #1 rstn_i = 1'b1;
    anr_mdio_host_i.pre_due = 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask
  ////////////////////////////////////////
  // reset values under basic-mode straps
  task automatic t_defaults();
    do_reset(1'b1, 4'b0101);
    rd_chk(ADDR_ADVERT, 16'h00A1);
    rd_chk(ADDR_PARTNER, 16'h0000);
    rd_chk(ADDR_EXPANSION, 16'h0004);
    rd_chk(ADDR_NEXT_PAGE, 16'h2001);
    rd_chk(5'h1F, 16'h0000);
  endtask
  // enhanced mode keeps the upper abilities set
  task automatic t_enhanced();
    do_reset(1'b0, 4'b0000);
    rd_chk(ADDR_ADVERT, 16'h01C1);
    #1 chk(advert_o, 16'h01C1);
  endtask
  // set and clear writable bits; forced mode masks abilities
  task automatic t_advert();
    wr(ADDR_ADVERT, 16'hDFFF);
    rd_chk(ADDR_ADVERT, 16'h8DFF);
    @(posedge sys_clk_i) #1 force_mode_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 chk(advert_o, 16'h8C1F);
    rd_chk(ADDR_ADVERT, 16'h8DFF);
    @(posedge sys_clk_i) #1 force_mode_i = 1'b0;
    wr(ADDR_ADVERT, 16'h0000);
    rd_chk(ADDR_ADVERT, 16'h0000);
  endtask
  // partner page, read-only write, sticky flags
  task automatic t_partner();
    @(posedge sys_clk_i) #1 lp_page_i = 16'hF5FE;
    lp_page_valid_i = 1'b1;
    pd_fault_i = 1'b1;
    lp_an_able_i = 1'b1;
    lp_np_able_i = 1'b1;
    @(posedge sys_clk_i) #1 lp_page_valid_i = 1'b0;
    pd_fault_i = 1'b0;
    lp_page_i = 16'h0000;
    rd_chk(ADDR_PARTNER, 16'hE5FE);
    wr(ADDR_PARTNER, 16'h0000);
    rd_chk(ADDR_PARTNER, 16'hE5FE);
    rd_chk(ADDR_EXPANSION, 16'h001F);
    rd_chk(ADDR_EXPANSION, 16'h000D);
    #1 lp_an_able_i = 1'b0;
    lp_np_able_i = 1'b0;
    rd_chk(ADDR_EXPANSION, 16'h0004);
  endtask
  // next page register writable bits
  task automatic t_next();
    wr(ADDR_NEXT_PAGE, 16'hFFFF);
    rd_chk(ADDR_NEXT_PAGE, 16'hB7FF);
    // a write to another management address must leave the word alone
    anr_mdio_host_i.frame(OP_WRITE, PHY ^ 5'h01, ADDR_NEXT_PAGE, 16'h0000, rv);
    rd_chk(ADDR_NEXT_PAGE, 16'hB7FF);
    #1 chk(next_page_o, 16'hB7FF);
  endtask
  ////////////////////////////////////////
  // watchdog
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    bad_count++;
    $display("watchdog expired");
    give_verdict();
  end
  // main sequence
  initial begin
    rstn_i = 1'b0;
    basic_mode_i = 1'b1;
    strap_adv_i = 4'h0;
    force_mode_i = 1'b0;
    lp_page_valid_i = 1'b0;
    lp_page_i = 16'h0000;
    lp_an_able_i = 1'b0;
    lp_np_able_i = 1'b0;
    pd_fault_i = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    t_defaults();
    t_enhanced();
    t_advert();
    t_partner();
    t_next();
    give_verdict();
  end
endmodule
